// ### bts_endpoint_core.sv
// Bulk endpoint toggle tracking, halt handling and high-bandwidth descriptor scheduling
`timescale 1ns/1ns
`default_nettype none
module bts_endpoint_core
   import bts_pkg::*;
#(
   parameter int MF_CYC = MF_CYCLES,
   parameter int BUF_DEPTH = 2
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Control events
   input wire logic cfg_set,
   input wire logic halt_set,
   input wire logic halt_clear,
   input wire logic sof,
   // Endpoint descriptor
   input wire logic [DESC_W-1:0] max_payload_descriptor_field,
   // Receive link
   input wire logic rx_start,
   input wire logic rx_pid_odd,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [BYTE_W-1:0] rx_data,
   input wire logic rx_end,
   input wire logic rx_crc_ok,
   // Handshake answer
   output logic hs_valid,
   output logic [1:0] hs_code,
   // Transmit link
   input wire logic tx_result_valid,
   input wire logic tx_acked,
   output logic tx_pid_odd,
   // User byte stream
   output logic usr_valid,
   input wire logic usr_ready,
   output logic [BYTE_W-1:0] usr_data,
   // Packet status
   output logic pkt_done,
   output logic pkt_good,
   output logic halted,
   // Periodic transaction accounting
   input wire logic hb_txn,
   output logic [PAYLOAD_W-1:0] hb_payload,
   output logic [1:0] hb_txn_max,
   output logic hb_high_bw,
   output logic hb_desc_err,
   output logic [CNT_W-1:0] hb_byte_cap,
   output logic hb_txn_over
);
   localparam int MW = $clog2(MF_CYC + 1);

   initial begin
      if (MF_CYC < 1) begin
         $error("bts_endpoint_core: MF_CYC must be at least 1");
      end
   end

   // Buffer links
   bts_stream_if #(.W(BYTE_W)) fill_if ();
   bts_stream_if #(.W(BYTE_W)) drain_if ();

   bts_rx_state_e st_reg, st_next;        // Receive state
   logic toggle_reg, toggle_next;         // Expected and sent data toggle
   logic halt_reg, halt_next;             // Pipe halted
   logic [CNT_W-1:0] cnt_reg, cnt_next;   // Bytes seen in this packet
   logic [1:0] hs_reg, hs_next;           // Handshake code
   logic hsv_reg, hsv_next;               // Handshake strobe
   logic done_reg, done_next;
   logic good_reg, good_next;
   logic [CNT_W-1:0] limit;               // Largest bulk payload accepted
   logic beat, oversize, ending;

   // Bulk limit is the descriptor payload, never above 512
   assign limit = (CNT_W'(max_payload_descriptor_field[PAYLOAD_W-1:0]) > BULK_HS_MAX)
      ? BULK_HS_MAX : CNT_W'(max_payload_descriptor_field[PAYLOAD_W-1:0]);
   // While skipping, bytes are swallowed so the link never waits on a dropped packet
   assign rx_ready = (st_reg == ST_RECV) ? fill_if.ready : 1'b1;
   assign beat = rx_valid && rx_ready && (st_reg != ST_IDLE);
   assign fill_if.valid = rx_valid && (st_reg == ST_RECV) && !halt_reg;
   assign fill_if.data = rx_data;
   assign oversize = (cnt_reg > limit);
   assign ending = rx_end && (st_reg != ST_IDLE);

   // Receive sequencing, toggle and halt next values
   always_comb begin
      st_next = st_reg;
      toggle_next = toggle_reg;
      halt_next = halt_reg;
      cnt_next = cnt_reg;
      hs_next = HS_NONE;
      hsv_next = 1'b0;
      done_next = 1'b0;
      good_next = 1'b0;
      if (beat && cnt_reg != {CNT_W{1'b1}}) begin
         cnt_next = cnt_reg + 1'b1;
      end
      unique case (st_reg)
         // Packet begins: sort by data toggle
         ST_IDLE: begin
            cnt_next = '0;
            if (rx_start) begin
               st_next = (rx_pid_odd == toggle_reg && !halt_reg) ? ST_RECV : ST_SKIP;
            end
         end
         ST_RECV, ST_SKIP: begin
            if (rx_end) begin
               st_next = ST_IDLE;
               done_next = 1'b1;
               if (halt_reg) begin
                  // Halted pipe answers every packet with a stall
                  hs_next = HS_STALL;
                  hsv_next = 1'b1;
               end else if (!rx_crc_ok || oversize) begin
                  hsv_next = 1'b0;
               end else if (st_reg == ST_RECV) begin
                  toggle_next = !toggle_reg;
                  hs_next = HS_ACK;
                  hsv_next = 1'b1;
                  good_next = 1'b1;
               end else begin
                  hs_next = HS_ACK;
                  hsv_next = 1'b1;
               end
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
      // transmit side flips on host acknowledge only
      if (tx_result_valid && tx_acked && !halt_reg) begin
         toggle_next = !toggle_reg;
      end
      if (cfg_set || halt_clear) begin
         toggle_next = TOGGLE_DATA0;
      end
      // A new halt wins over a clear in the same cycle
      if (halt_set) begin
         halt_next = 1'b1;
      end else if (halt_clear) begin
         halt_next = 1'b0;
      end
   end

   // Receive group registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_IDLE;
         toggle_reg <= TOGGLE_DATA0;
         halt_reg <= 1'b0;
         cnt_reg <= '0;
         hs_reg <= HS_NONE;
         hsv_reg <= 1'b0;
         done_reg <= 1'b0;
         good_reg <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
         toggle_reg <= toggle_next;
         halt_reg <= halt_next;
         cnt_reg <= cnt_next;
         hs_reg <= hs_next;
         hsv_reg <= hsv_next;
         done_reg <= done_next;
         good_reg <= good_next;
      end
   end

   assign hs_valid = hsv_reg;
   assign hs_code = hs_reg;
   assign tx_pid_odd = toggle_reg;
   assign pkt_done = done_reg;
   assign pkt_good = good_reg;
   assign halted = halt_reg;

   // Two-entry buffer between link and user
   bts_skid_buf #(.WIDTH(BYTE_W), .DEPTH(BUF_DEPTH)) u_buf (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .fill(fill_if.snk),
      .drain(drain_if.src)
   );
   assign usr_valid = drain_if.valid;
   assign usr_data = drain_if.data;
   assign drain_if.ready = usr_ready;

   logic [PAYLOAD_W-1:0] pay_reg, pay_next;   // Per-transaction payload
   logic [1:0] tmax_reg, tmax_next;           // Transactions allowed
   logic hbw_reg, hbw_next;
   logic derr_reg, derr_next;
   logic [CNT_W-1:0] cap_reg, cap_next;       // Bytes per microframe
   logic [1:0] tcnt_reg, tcnt_next;           // Transactions seen
   logic over_reg, over_next;
   logic [MW-1:0] mf_reg, mf_next;            // Microframe timer
   logic mf_edge;

   // Own timer covers a missed start-of-frame marker
   assign mf_edge = sof || (mf_reg == MW'(MF_CYC - 1));

   // Descriptor decode and per-microframe counting
   always_comb begin
      pay_next = max_payload_descriptor_field[PAYLOAD_LSB +: PAYLOAD_W];
      tmax_next = bts_txn_count(max_payload_descriptor_field);
      hbw_next = (max_payload_descriptor_field[TXN_LSB +: TXN_W] != 2'h0);
      derr_next = bts_desc_bad(max_payload_descriptor_field);
      // cap of 3072 bytes per microframe
      cap_next = derr_next ? '0
         : CNT_W'(13'(pay_next) * 13'(bts_txn_count(max_payload_descriptor_field)));
      mf_next = mf_edge ? '0 : mf_reg + 1'b1;
      tcnt_next = mf_edge ? 2'h0 : tcnt_reg;
      over_next = mf_edge ? 1'b0 : over_reg;
      if (hb_txn) begin
         // A transaction in the boundary cycle counts for the new microframe
         // more than allowed flags overrun
         if (tcnt_next >= tmax_reg) begin
            over_next = 1'b1;
         end else begin
            tcnt_next = tcnt_next + 2'h1;
         end
      end
   end

   // Scheduling registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pay_reg <= '0;
         tmax_reg <= 2'h0;
         hbw_reg <= 1'b0;
         derr_reg <= 1'b0;
         cap_reg <= '0;
         tcnt_reg <= 2'h0;
         over_reg <= 1'b0;
         mf_reg <= '0;
      end else if (ce) begin
         pay_reg <= pay_next;
         tmax_reg <= tmax_next;
         hbw_reg <= hbw_next;
         derr_reg <= derr_next;
         cap_reg <= cap_next;
         tcnt_reg <= tcnt_next;
         over_reg <= over_next;
         mf_reg <= mf_next;
      end
   end

   assign hb_payload = pay_reg;
   assign hb_txn_max = tmax_reg;
   assign hb_high_bw = hbw_reg;
   assign hb_desc_err = derr_reg;
   assign hb_byte_cap = cap_reg;
   assign hb_txn_over = over_reg;

   a_cfg_toggle_zero: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && cfg_set |=> !toggle_reg)
      else $error("toggle not DATA0 after configuration");

   a_clear_toggle_zero: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && halt_clear && !halt_set |=> !toggle_reg && !halt_reg)
      else $error("halt clear did not restore DATA0");

   a_fail_keeps_toggle: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && tx_result_valid && !tx_acked && !cfg_set && !halt_clear && !ending
      |=> $stable(toggle_reg))
      else $error("toggle moved on failed transaction");

   a_good_rx_flips: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && st_reg == ST_RECV && rx_end && rx_crc_ok && !oversize && !halt_reg
      && !cfg_set && !halt_clear && !tx_result_valid
      |=> toggle_reg != $past(toggle_reg) && hsv_reg && hs_reg == HS_ACK && good_reg)
      else $error("good packet did not flip toggle with ACK");

   a_dup_ack_hold: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && st_reg == ST_SKIP && rx_end && rx_crc_ok && !oversize && !halt_reg
      && !cfg_set && !halt_clear && !tx_result_valid
      |=> $stable(toggle_reg) && hs_reg == HS_ACK && !good_reg)
      else $error("duplicate packet handled wrongly");

   a_dup_no_store: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      st_reg == ST_SKIP |-> !fill_if.valid)
      else $error("skipped payload reached buffer");

   a_oversize_no_ack: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce && ending && oversize && !halt_reg |=> !hsv_reg && !good_reg)
      else $error("oversize packet acknowledged");

   a_hb_flag_bits: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce |=> hb_high_bw == ($past(max_payload_descriptor_field[12:11]) != 2'h0))
      else $error("high bandwidth flag wrong");

   a_payload_decode: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ce |=> hb_payload == $past(max_payload_descriptor_field[10:0])
      && (hb_desc_err || hb_txn_max == $past(max_payload_descriptor_field[12:11]) + 2'h1))
      else $error("descriptor decode wrong");

   a_hb_byte_cap: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      hb_byte_cap <= 12'hc00 && (!hb_desc_err || hb_byte_cap == 12'h000))
      else $error("microframe byte cap above 3072");
endmodule
`default_nettype wire

// ### bts_pkg.sv
// Shared constants, types and decode functions for the bulk toggle and high-bandwidth block
// Behaviour
// - Toggle flips only on success, kept on retry
// - Configuration sets the toggle to DATA0
// - Halt clear returns toggle to DATA0
// - One to three transactions, 3072 bytes max
// - Nonzero bits 12..11 mark high bandwidth
// - Bits 10..0 payload, 12..11 count, rest zero
// - Bulk payload never above reported maximum, 512
package bts_pkg;

   // Clock and microframe timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int MF_TIME_NS = 125000;
   localparam int MF_CYCLES = MF_TIME_NS / CLK_PERIOD_NS;

   // Descriptor field layout
   localparam int DESC_W = 16;
   localparam int PAYLOAD_LSB = 0;
   localparam int PAYLOAD_W = 11;
   localparam int TXN_LSB = 11;
   localparam int TXN_W = 2;
   localparam int RSVD_LSB = 13;
   localparam int RSVD_W = 3;

   // Size limits
   localparam logic [10:0] HB_PAYLOAD_MAX = 11'h400;
   localparam logic [11:0] MF_BYTES_MAX = 12'hc00;
   localparam logic [11:0] BULK_HS_MAX = 12'h200;
   localparam logic [1:0] TXN_FIELD_RSVD = 2'h3;

   // Byte stream width
   localparam int BYTE_W = 8;
   localparam int CNT_W = 12;

   // Reset values
   localparam logic TOGGLE_DATA0 = 1'b0;

   // Handshake answer codes
   typedef enum logic [1:0] {
      HS_NONE = 2'h0,
      HS_ACK = 2'h1,
      HS_STALL = 2'h2
   } bts_hs_e;

   // Receive states, Gray along idle, receive, skip
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RECV = 2'h1,
      ST_SKIP = 2'h3
   } bts_rx_state_e;

   // Transactions per microframe, one to three; zero for the reserved count field
   function automatic logic [1:0] bts_txn_count(input logic [DESC_W-1:0] desc);
      logic [1:0] field;
      field = desc[TXN_LSB +: TXN_W];
      bts_txn_count = (field == TXN_FIELD_RSVD) ? 2'h0 : field + 2'h1;
   endfunction

   // Descriptor that no endpoint may report
   function automatic logic bts_desc_bad(input logic [DESC_W-1:0] desc);
      bts_desc_bad = (desc[RSVD_LSB +: RSVD_W] != 3'h0)
         || (desc[TXN_LSB +: TXN_W] == TXN_FIELD_RSVD)
         || (desc[PAYLOAD_LSB +: PAYLOAD_W] > HB_PAYLOAD_MAX);
   endfunction

endpackage

// ### bts_stream_if.sv
// Valid/ready byte stream carrier between the core and its buffer
`timescale 1ns/1ns
`default_nettype none
interface bts_stream_if #(parameter int W = 8) ();
   // Handshake pair and payload
   logic valid;
   logic ready;
   logic [W-1:0] data;

   // Producer side
   modport src (output valid, output data, input ready);
   // Consumer side
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### bts_skid_buf.sv
// Small flip-flop FIFO that absorbs a receiver stall without losing a byte
`timescale 1ns/1ns
`default_nettype none
module bts_skid_buf
   import bts_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Filling and draining sides
   bts_stream_if.snk fill,
   bts_stream_if.src drain
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer arithmetic wraps naturally only for powers of two
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("bts_skid_buf: DEPTH must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW:0] wr_reg, wr_next;       // Write pointer with wrap bit
   logic [AW:0] rd_reg, rd_next;       // Read pointer with wrap bit
   logic full, empty, push, pop;

   // Full when the pointers differ only in the wrap bit
   assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
   assign empty = (wr_reg == rd_reg);
   assign fill.ready = !full;
   assign drain.valid = !empty;
   assign drain.data = mem_reg[rd_reg[AW-1:0]];
   assign push = fill.valid && !full;
   assign pop = drain.ready && !empty;

   // Next pointers and storage
   always_comb begin
      mem_next = mem_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      if (push) begin
         mem_next[wr_reg[AW-1:0]] = fill.data;
         wr_next = wr_reg + 1'b1;
      end
      if (pop) begin
         rd_next = rd_reg + 1'b1;
      end
   end

   // Register, frozen while ce is low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (ce) begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         mem_reg <= mem_next;
      end
   end
endmodule
`default_nettype wire

// ### bts_host_model.sv
// Host controller model that sends bulk OUT data packets to the endpoint core
`timescale 1ns/1ns
`default_nettype none
module bts_host_model
   import bts_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Data packet link towards the endpoint
   output logic rx_start,
   output logic rx_pid_odd,
   output logic rx_valid,
   output logic [BYTE_W-1:0] rx_data,
   output logic rx_end,
   output logic rx_crc_ok,
   input wire logic rx_ready,
   // Handshake from the endpoint
   input wire logic hs_valid,
   input wire logic [1:0] hs_code
);
   // Host copy of the pipe toggle
   logic toggle_reg;
   // Transfer requests still queued on the pipe
   int pending;
   // Flow-control waits that ran out
   int timeouts;

   initial begin
      toggle_reg = TOGGLE_DATA0;
      pending = 0;
      timeouts = 0;
      rx_start = 1'b0;
      rx_pid_odd = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_end = 1'b0;
      rx_crc_ok = 1'b0;
   end

   task automatic reset_pipe();
      toggle_reg = TOGGLE_DATA0;
   endtask

   // One data packet; gap idles the link between bytes to act as a slow host
   task automatic xfer(input int n, input logic [7:0] base, input logic crc_ok,
         input logic bad_pid, input int gap, output logic [2:0] ans);
      int w;
      @(negedge ref_clk);
      rx_start = 1'b1;
      rx_pid_odd = toggle_reg ^ bad_pid;
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         rx_start = 1'b0;
         // Released data line must not keep the last byte
         if (gap > 0) begin
            rx_valid = 1'b0;
            rx_data = ~rx_data;
            repeat (gap) @(negedge ref_clk);
         end
         rx_valid = 1'b1;
         rx_data = base + 8'(i);
         w = 0;
         #1;
         // Hold the byte until the endpoint shows ready before an edge
         while (!rx_ready && w < 200) begin
            w++;
            @(negedge ref_clk);
            #1;
         end
         if (w >= 200) begin
            timeouts++;
         end
      end
      @(negedge ref_clk);
      rx_start = 1'b0;
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      rx_end = 1'b1;
      rx_crc_ok = crc_ok;
      @(negedge ref_clk);
      rx_end = 1'b0;
      rx_crc_ok = ~crc_ok;
      ans = {hs_valid, hs_code};
      if (hs_valid && hs_code == HS_ACK && !bad_pid) begin
         toggle_reg = ~toggle_reg;
      end
      if (hs_valid && hs_code == HS_STALL) begin
         pending = 0;
      end else if (hs_valid && hs_code == HS_ACK && pending > 0) begin
         pending--;
      end
   endtask
endmodule
`default_nettype wire

// ### bts_endpoint_core_bench.sv
// Self-checking bench for the bulk toggle and high-bandwidth endpoint core
`timescale 1ns/1ns
`default_nettype none
module bts_endpoint_core_bench
   import bts_pkg::*;
;
   // Clock, reset and control events
   logic ref_clk, rst_n, ce, cfg_set, halt_set, halt_clear, sof, hb_txn;
   logic [DESC_W-1:0] desc;
   // Receive link driven by the host model
   logic rx_start, rx_pid_odd, rx_valid, rx_ready, rx_end, rx_crc_ok;
   logic [BYTE_W-1:0] rx_data, usr_data;
   // Outputs and transmit result inputs
   logic hs_valid, tx_result_valid, tx_acked, tx_pid_odd, usr_valid, usr_ready;
   logic [1:0] hs_code, hb_txn_max;
   logic pkt_done, pkt_good, halted, hb_high_bw, hb_desc_err, hb_txn_over;
   logic [PAYLOAD_W-1:0] hb_payload;
   logic [CNT_W-1:0] hb_byte_cap;
   // Bytes seen on the user stream, in arrival order
   logic [7:0] got_q[$];
   int n_mismatch = 0;
   int n_tests = 0;

   // Short microframe timer keeps the run brief
   bts_endpoint_core #(.MF_CYC(50)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .cfg_set(cfg_set), .halt_set(halt_set), .halt_clear(halt_clear), .sof(sof),
      .max_payload_descriptor_field(desc), .rx_start(rx_start), .rx_pid_odd(rx_pid_odd),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_end(rx_end),
      .rx_crc_ok(rx_crc_ok), .hs_valid(hs_valid), .hs_code(hs_code),
      .tx_result_valid(tx_result_valid), .tx_acked(tx_acked), .tx_pid_odd(tx_pid_odd),
      .usr_valid(usr_valid), .usr_ready(usr_ready), .usr_data(usr_data),
      .pkt_done(pkt_done), .pkt_good(pkt_good), .halted(halted), .hb_txn(hb_txn),
      .hb_payload(hb_payload), .hb_txn_max(hb_txn_max), .hb_high_bw(hb_high_bw),
      .hb_desc_err(hb_desc_err), .hb_byte_cap(hb_byte_cap), .hb_txn_over(hb_txn_over));

   bts_host_model host (.ref_clk(ref_clk), .rx_start(rx_start), .rx_pid_odd(rx_pid_odd),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
      .rx_ready(rx_ready), .hs_valid(hs_valid), .hs_code(hs_code));

   // User side sink; flops update after this samples, so pre-edge values are seen
   always @(posedge ref_clk) begin
      if (usr_valid && usr_ready) begin
         got_q.push_back(usr_data);
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         n_mismatch++;
      end
   endtask

   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One-cycle event on a control input
   task automatic pulse(ref logic s);
      @(negedge ref_clk);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
   endtask

   // Packet through the host model; a stuck handshake ends the run
   task automatic pkt(input int n, input logic [7:0] b, input logic ok, input logic bad,
         input int gap, output logic [2:0] a);
      host.xfer(n, b, ok, bad, gap, a);
      if (host.timeouts != 0) begin
         n_mismatch++;
         print_verdict();
      end
   endtask

   // Configure, then two good packets back to back
   task automatic t_basic();
      logic [2:0] a;
      pulse(cfg_set);
      check(tx_pid_odd, TOGGLE_DATA0);
      got_q.delete();
      pkt(2, 8'h10, 1'b1, 1'b0, 0, a);
      check(a, {1'b1, HS_ACK});
      check({pkt_done, pkt_good, tx_pid_odd}, 3'b111);
      pkt(1, 8'h12, 1'b1, 1'b0, 0, a);
      check({a, pkt_good, tx_pid_odd}, {1'b1, HS_ACK, 2'b10});
      repeat (3) @(negedge ref_clk);
      check(16'(got_q.size()), 16'h3);
      check({got_q[0], got_q[1]}, 16'h1011);
   endtask

   // Bad CRC gets no handshake, then the retry succeeds
   task automatic t_retry();
      logic [2:0] a;
      pkt(3, 8'h20, 1'b0, 1'b0, 0, a);
      check({a[2], pkt_done, pkt_good, tx_pid_odd}, 4'b0100);
      pkt(3, 8'h20, 1'b1, 1'b0, 0, a);
      check({a, pkt_good, tx_pid_odd}, {1'b1, HS_ACK, 2'b11});
   endtask

   // Duplicate with the wrong toggle is acknowledged and dropped
   task automatic t_mismatch();
      logic [2:0] a;
      got_q.delete();
      pkt(2, 8'h30, 1'b1, 1'b1, 0, a);
      check({a, pkt_good, tx_pid_odd}, {1'b1, HS_ACK, 2'b01});
      repeat (3) @(negedge ref_clk);
      check(16'(got_q.size()), 16'h0);
   endtask

   // Transmit result: failure keeps the toggle, ACK flips it
   task automatic t_txres();
      pulse(cfg_set);
      host.reset_pipe();
      tx_acked = 1'b0;
      pulse(tx_result_valid);
      check(tx_pid_odd, 1'b0);
      tx_acked = 1'b1;
      pulse(tx_result_valid);
      check(tx_pid_odd, 1'b1);
      // Enable low freezes the toggle even on an acknowledge
      ce = 1'b0;
      pulse(tx_result_valid);
      ce = 1'b1;
      check(tx_pid_odd, 1'b1);
   endtask

   // Halted pipe stalls and frees requests; clearing returns DATA0
   task automatic t_halt();
      logic [2:0] a;
      pulse(halt_set);
      check(halted, 1'b1);
      host.pending = 3;
      pkt(1, 8'h50, 1'b1, 1'b0, 0, a);
      check({a, tx_pid_odd}, {1'b1, HS_STALL, 1'b1});
      check(16'(host.pending), 16'h0);
      pulse(halt_clear);
      host.reset_pipe();
      check({halted, tx_pid_odd}, 2'b00);
   endtask

   // User stalls while a slow host sends five bytes through the two-entry buffer
   task automatic t_stall();
      logic [2:0] a;
      got_q.delete();
      usr_ready = 1'b0;
      fork
         pkt(5, 8'h40, 1'b1, 1'b0, 1, a);
         begin
            repeat (16) @(negedge ref_clk);
            check(rx_ready, 1'b0);
            usr_ready = 1'b1;
         end
      join
      check(a, {1'b1, HS_ACK});
      repeat (3) @(negedge ref_clk);
      check(16'(got_q.size()), 16'h5);
      for (int i = 0; i < 5; i++) begin
         check(got_q[i], 8'h40 + 8'(i));
      end
   endtask

   // Packet longer than the reported payload is refused
   task automatic t_oversize();
      logic [2:0] a;
      desc = 16'h0002;
      pkt(3, 8'h60, 1'b1, 1'b0, 0, a);
      check({a[2], pkt_done, pkt_good, tx_pid_odd}, 4'b0101);
      desc = 16'h0200;
   endtask

   // Descriptor decode table: payload, count, high bandwidth, error, byte cap
   task automatic t_desc();
      logic [15:0] d[5] = '{16'h0200, 16'h0c00, 16'h1400, 16'h1800, 16'h2010};
      logic [10:0] pl[5] = '{11'h200, 11'h400, 11'h400, 11'h000, 11'h010};
      logic [1:0] mx[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
      logic [1:0] he[5] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h1};
      logic [11:0] cp[5] = '{12'h200, 12'h800, 12'hc00, 12'h000, 12'h000};
      for (int i = 0; i < 5; i++) begin
         @(negedge ref_clk);
         desc = d[i];
         repeat (2) @(negedge ref_clk);
         check({hb_payload, hb_txn_max}, {pl[i], mx[i]});
         check({hb_high_bw, hb_desc_err}, he[i]);
         check(hb_byte_cap, cp[i]);
      end
   endtask

   // Two allowed transactions per microframe, the third flags overrun
   task automatic t_sched();
      desc = 16'h0c00;
      pulse(sof);
      pulse(hb_txn);
      pulse(hb_txn);
      check(hb_txn_over, 1'b0);
      pulse(hb_txn);
      check(hb_txn_over, 1'b1);
      pulse(sof);
      check(hb_txn_over, 1'b0);
      repeat (3) pulse(hb_txn);
      check(hb_txn_over, 1'b1);
      repeat (52) @(negedge ref_clk);
      check(hb_txn_over, 1'b0);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      {rst_n, cfg_set, halt_set, halt_clear, sof, hb_txn} = 6'h00;
      {tx_result_valid, tx_acked} = 2'h0;
      ce = 1'b1;
      usr_ready = 1'b1;
      desc = 16'h0200;
      repeat (8) @(negedge ref_clk);
      check({tx_pid_odd, usr_valid, rx_ready, halted}, 4'b0010);
      rst_n = 1'b1;
      t_basic();
      t_retry();
      t_mismatch();
      t_txres();
      t_halt();
      t_stall();
      t_oversize();
      t_desc();
      t_sched();
      print_verdict();
   end
endmodule
`default_nettype wire
